// [hw/cps_pkg.sv]
package cps_pkg;

  // ---------------------------------------------------------------------
  // Command encodings as {ras_n, cas_n, we_n} with chip select low.
  // ---------------------------------------------------------------------
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [2:0] CMD_REF = 3'h1;

  // ---------------------------------------------------------------------
  // Synchroniser widths and bit positions of the crossing words.
  // ---------------------------------------------------------------------
  localparam int CORE_W = 4;
  localparam int CORE_OPEN = 3;
  localparam int CORE_BUSY = 2;
  localparam int CORE_RFSH = 1;
  localparam int CORE_TIME = 0;

  localparam int STAT_W = 6;
  localparam int STAT_CKE = 5;
  localparam int STAT_ODT = 4;
  localparam int STAT_ILL = 3;
  localparam int STAT_PD = 2;
  localparam int STAT_APD = 1;
  localparam int STAT_SR = 0;

  localparam int LVL_W = 3;
  localparam int LVL_PD = 2;
  localparam int LVL_APD = 1;
  localparam int LVL_SR = 0;

  // ---------------------------------------------------------------------
  // Power state of the device as seen at the clock-enable pin.
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    PW_ON,
    PW_PEND,
    PW_PPD,
    PW_APD,
    PW_SR
  } cps_pw_type;

endpackage

// [hw/cps_sync.sv]
`timescale 1ns/1ns
`default_nettype none

// -----------------------------------------------------------------------
// Two-stage level synchroniser; each bit is an independent level.
// -----------------------------------------------------------------------
module cps_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // The first stage feeds only the second stage, never any logic.
  always_ff @(posedge clk) begin
    meta_ff <= din;
    sync_ff <= meta_ff;
  end

  assign dout = sync_ff;

endmodule // cps_sync

`default_nettype wire

// [hw/cps_power_ctrl.sv]
// Summary of operation
// R1 - Transitions use clock enable now and at the previous edge.
// R2 - State is that before the edge; act on command at that edge.
// R3 - Controller holds each new clock-enable level for the minimum pulse.
// R4 - Controller lowers clock enable only after mode-register delays.
// R5 - Power-down entry or exit only with no-op or deselect; else illegal.
// R6 - Enable falling during an operation: precharge or active power-down.
// R7 - No internal refresh while in power-down.
// R8 - Refresh with enable falling enters self refresh, only from idle.
// R9 - Idle means banks closed, enable high, all timings met.
// R10 - Self-refresh exit only with no-op or deselect.
// R11 - Controller sends no-ops until self-refresh exit time has passed.
// R12 - Controller waits relock time before reads or termination commands.
// R13 - Enable held low in low power: pins ignored, state kept.
// R14 - Termination off in self refresh; it never steers transitions.
// R15 - Unlisted combinations are illegal; controller never makes them.
// R16 - Controller doubles refresh rate in the extended temperature range.
// R17 - Controller sets mode register 2 self-refresh temperature bits.
// R18 - Commands decode from select, strobes, write enable, clock enable.
// R19 - Deselect acts exactly like no-operation.
// R20 - Self-refresh exit is seen without relying on the link clock.
// R21 - Controller leaves power-down in time for pending refreshes.
`timescale 1ns/1ns
`default_nettype none

module cps_power_ctrl
  import cps_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic dram_ck,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic odt,
  input wire logic banks_open,
  input wire logic op_busy,
  input wire logic refresh_busy,
  input wire logic timings_met,
  output logic power_down,
  output logic active_power_down,
  output logic self_refresh,
  output logic refresh_run,
  output logic odt_enable,
  output logic illegal_cmd,
  output logic sr_wake
);

  // ---------------------------------------------------------------------
  // Crossings between the core clock and the link clock.
  // ---------------------------------------------------------------------
  logic lrst;
  logic [CORE_W-1:0] core_s;
  logic [STAT_W-1:0] stat_s;
  logic [LVL_W-1:0] lvl_ff;
  logic ill_tgl_ff;

  // Reset reaches the link domain through its own synchroniser.
  cps_sync #(.WIDTH(1)) u_rst_sync (
    .clk(dram_ck),
    .din(rst),
    .dout(lrst)
  );

  // Bank and timing status from the core, all independent levels.
  cps_sync #(.WIDTH(CORE_W)) u_core_sync (
    .clk(dram_ck),
    .din({banks_open, op_busy, refresh_busy, timings_met}),
    .dout(core_s)
  );

  // Pins and link-side levels seen from the core clock; illegal events
  // travel as a toggle so that none is lost when the link clock is fast.
  cps_sync #(.WIDTH(STAT_W)) u_stat_sync (
    .clk(mclk),
    .din({cke, odt, ill_tgl_ff, lvl_ff}),
    .dout(stat_s)
  );

  // ---------------------------------------------------------------------
  // Link-domain command decode.
  // ---------------------------------------------------------------------
  logic s_open;
  logic s_busy;
  logic s_rfsh;
  logic s_time;
  logic is_idle_cmd;
  logic is_ref_cmd;
  logic idle_ok;
  logic cke_prev_ff;

  assign s_open = core_s[CORE_OPEN];
  assign s_busy = core_s[CORE_BUSY];
  assign s_rfsh = core_s[CORE_RFSH];
  assign s_time = core_s[CORE_TIME];

  // Commands are the pin levels at the rising link edge; a deselect is
  // folded into the no-op so both steer the state identically.
  assign is_idle_cmd = cs_n | ({ras_n, cas_n, we_n} == CMD_NOP); // R18 R19
  assign is_ref_cmd = !cs_n && ({ras_n, cas_n, we_n} == CMD_REF); // R18

  // Idle needs closed banks, a high enable and every timing satisfied.
  assign idle_ok = !s_open && !s_busy && !s_rfsh && s_time
                   && cke_prev_ff; // R9

  // ---------------------------------------------------------------------
  // Link-domain power state machine.
  // ---------------------------------------------------------------------
  cps_pw_type pw_ff;
  cps_pw_type nxt_pw;
  logic nxt_cke_prev;
  logic nxt_ill_tgl;
  logic [LVL_W-1:0] nxt_lvl;

  // The termination pin is not read here, so it cannot steer any move.
  always_comb begin
    nxt_pw = pw_ff; // R2
    nxt_ill_tgl = ill_tgl_ff;
    nxt_cke_prev = cke; // R1
    unique case (pw_ff)
      PW_ON: begin
        if (cke_prev_ff && !cke) begin // R1
          if (is_ref_cmd) begin
            if (idle_ok) begin
              nxt_pw = PW_SR; // R8
            end else begin
              nxt_ill_tgl = !ill_tgl_ff; // R8 R15
            end
          end else if (!is_idle_cmd) begin
            nxt_ill_tgl = !ill_tgl_ff; // R5 R15
          end else if (s_busy) begin
            nxt_pw = PW_PEND; // R6
          end else if (s_rfsh || !s_open) begin
            nxt_pw = PW_PPD;
          end else begin
            nxt_pw = PW_APD;
          end
        end
      end
      PW_PEND: begin
        // Bank status is judged when the pending operation finishes.
        if (!cke_prev_ff && cke) begin
          if (is_idle_cmd) begin
            nxt_pw = PW_ON; // R5
          end else begin
            nxt_ill_tgl = !ill_tgl_ff; // R5 R15
          end
        end else if (!cke_prev_ff && !cke && !s_busy) begin
          nxt_pw = s_open ? PW_APD : PW_PPD; // R6
        end
      end
      PW_PPD, PW_APD, PW_SR: begin
        // While the enable stays low the command pins are not looked at.
        if (!cke_prev_ff && cke) begin // R13
          if (is_idle_cmd) begin
            nxt_pw = PW_ON; // R5 R10
          end else begin
            nxt_ill_tgl = !ill_tgl_ff; // R5 R10 R15
          end
        end
      end
      default: begin
        nxt_pw = PW_ON;
      end
    endcase
    nxt_lvl = '0;
    nxt_lvl[LVL_PD] = (nxt_pw == PW_PPD) || (nxt_pw == PW_APD);
    nxt_lvl[LVL_APD] = (nxt_pw == PW_APD);
    nxt_lvl[LVL_SR] = (nxt_pw == PW_SR);
  end

  // Levels for the core are registered so no decode glitch crosses.
  always_ff @(posedge dram_ck) begin
    if (lrst) begin
      pw_ff <= PW_ON;
      cke_prev_ff <= 1'b0;
      ill_tgl_ff <= 1'b0;
      lvl_ff <= '0;
    end else begin
      pw_ff <= nxt_pw;
      cke_prev_ff <= nxt_cke_prev;
      ill_tgl_ff <= nxt_ill_tgl;
      lvl_ff <= nxt_lvl;
    end
  end

  // ---------------------------------------------------------------------
  // Core-domain status outputs.
  // ---------------------------------------------------------------------
  logic pd_ff;
  logic apd_ff;
  logic sr_ff;
  logic rfsh_ff;
  logic odt_ff;
  logic ill_ff;
  logic wake_ff;
  logic ill_d_ff;
  logic cke_d_ff;
  logic [LVL_W-1:0] lvl_d_ff;
  logic [LVL_W-1:0] lvl_now;
  logic lvl_same;
  logic nxt_pd;
  logic nxt_apd;
  logic nxt_sr;
  logic nxt_rfsh;
  logic nxt_odt;
  logic nxt_ill;
  logic nxt_wake;

  // The wake pulse uses the core clock, since the link clock may be
  // stopped in self refresh; it costs three core cycles of latency.
  // The state levels are a word of several bits, so a new value is taken
  // only once two samples agree; a move that flips two bits can then never
  // show a false state between them, at one more core cycle of latency.
  always_comb begin
    lvl_now = {stat_s[STAT_PD], stat_s[STAT_APD], stat_s[STAT_SR]};
    lvl_same = (lvl_now == lvl_d_ff);
    nxt_pd = lvl_same ? stat_s[STAT_PD] : pd_ff;
    nxt_apd = lvl_same ? stat_s[STAT_APD] : apd_ff;
    nxt_sr = lvl_same ? stat_s[STAT_SR] : sr_ff;
    nxt_rfsh = nxt_sr && !nxt_pd; // R7
    nxt_odt = stat_s[STAT_ODT] && !nxt_sr; // R14
    nxt_ill = stat_s[STAT_ILL] ^ ill_d_ff;
    nxt_wake = stat_s[STAT_SR] && stat_s[STAT_CKE] && !cke_d_ff; // R20
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pd_ff <= 1'b0;
      apd_ff <= 1'b0;
      sr_ff <= 1'b0;
      rfsh_ff <= 1'b0;
      odt_ff <= 1'b0;
      ill_ff <= 1'b0;
      wake_ff <= 1'b0;
      ill_d_ff <= 1'b0;
      cke_d_ff <= 1'b0;
      lvl_d_ff <= '0;
    end else begin
      pd_ff <= nxt_pd;
      apd_ff <= nxt_apd;
      sr_ff <= nxt_sr;
      rfsh_ff <= nxt_rfsh;
      odt_ff <= nxt_odt;
      ill_ff <= nxt_ill;
      wake_ff <= nxt_wake;
      ill_d_ff <= stat_s[STAT_ILL];
      cke_d_ff <= stat_s[STAT_CKE];
      lvl_d_ff <= lvl_now;
    end
  end

  assign power_down = pd_ff;
  assign active_power_down = apd_ff;
  assign self_refresh = sr_ff;
  assign refresh_run = rfsh_ff;
  assign odt_enable = odt_ff;
  assign illegal_cmd = ill_ff;
  assign sr_wake = wake_ff;

  // ---------------------------------------------------------------------
  // Assertions and covers.
  // ---------------------------------------------------------------------
  logic pd_state;
  assign pd_state = (pw_ff == PW_PPD) || (pw_ff == PW_APD);

  pd_exit_ok_a: assert property (@(posedge dram_ck) disable iff (lrst) // R5
    (pd_state && !cke_prev_ff && cke && is_idle_cmd) |=> pw_ff == PW_ON)
    else $error("power-down exit with no-op not taken");

  low_hold_a: assert property (@(posedge dram_ck) disable iff (lrst) // R13
    ((pd_state || pw_ff == PW_SR) && !cke_prev_ff && !cke)
    |=> $stable(pw_ff) && $stable(ill_tgl_ff))
    else $error("low-power state changed while enable held low");

  sr_entry_a: assert property (@(posedge dram_ck) disable iff (lrst) // R8
    (pw_ff == PW_ON && cke_prev_ff && !cke && is_ref_cmd && idle_ok)
    |=> pw_ff == PW_SR ##1 (pw_ff == PW_SR || cke_prev_ff))
    else $error("self refresh not entered from idle");

  sr_guard_a: assert property (@(posedge dram_ck) disable iff (lrst) // R9
    (pw_ff == PW_ON && cke_prev_ff && !cke && is_ref_cmd && !idle_ok)
    |=> pw_ff == PW_ON && $changed(ill_tgl_ff))
    else $error("self refresh entered while not idle");

  pd_bad_cmd_a: assert property (@(posedge dram_ck) disable iff (lrst) // R5
    (pw_ff == PW_ON && cke_prev_ff && !cke && !is_idle_cmd && !is_ref_cmd)
    |=> pw_ff == PW_ON && $changed(ill_tgl_ff))
    else $error("power-down entry with a wrong command accepted");

  sr_bad_exit_a: assert property (@(posedge dram_ck) disable iff (lrst) // R10
    (pw_ff == PW_SR && !cke_prev_ff && cke && !is_idle_cmd)
    |=> pw_ff == PW_SR && $changed(ill_tgl_ff))
    else $error("self refresh left on a wrong command");

  pend_apd_a: assert property (@(posedge dram_ck) disable iff (lrst) // R6
    (pw_ff == PW_PEND && !cke_prev_ff && !cke && !s_busy)
    |=> pw_ff == ($past(s_open) ? PW_APD : PW_PPD))
    else $error("pending power-down resolved to the wrong kind");

  apd_entry_a: assert property (@(posedge dram_ck) disable iff (lrst) // R6
    (pw_ff == PW_ON && cke_prev_ff && !cke && is_idle_cmd && !s_busy
     && !s_rfsh && s_open) |=> pw_ff == PW_APD ##1 lvl_ff[LVL_APD])
    else $error("active power-down not entered with open banks");

  odt_off_a: assert property (@(posedge mclk) disable iff (rst) // R14
    sr_ff |-> !odt_ff)
    else $error("termination enabled during self refresh");

  refresh_off_a: assert property (@(posedge mclk) disable iff (rst) // R7
    pd_ff |-> !rfsh_ff)
    else $error("internal refresh running in power-down");

  wake_a: assert property (@(posedge mclk) disable iff (rst) // R20
    (stat_s[STAT_SR] && stat_s[STAT_CKE] && !cke_d_ff) |=> sr_wake)
    else $error("self-refresh wake not flagged");

  sr_seen_c: cover property (@(posedge dram_ck) disable iff (lrst)
    pw_ff == PW_ON ##1 pw_ff == PW_SR);
  apd_seen_c: cover property (@(posedge dram_ck) disable iff (lrst)
    pw_ff == PW_PEND ##1 pw_ff == PW_APD);
  ppd_exit_c: cover property (@(posedge dram_ck) disable iff (lrst)
    pw_ff == PW_PPD ##1 pw_ff == PW_ON);
  illegal_c: cover property (@(posedge mclk) disable iff (rst) ill_ff);

endmodule // cps_power_ctrl

`default_nettype wire

// [bench/cps_ctrl_model.sv]
`timescale 1ns/1ns
`default_nettype none

// --------------------------------------------
// Controller model on the far side of the link.
// --------------------------------------------
module cps_ctrl_model #(
  parameter int HOLD = 3
) (
  output logic dram_ck,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n
);
  logic [3:0] pins;

  // Command pins travel as one word {cs_n, ras_n, cas_n, we_n}.
  assign {cs_n, ras_n, cas_n, we_n} = pins;

  // The clock runs free so that the link side sees every reset.
  initial dram_ck = 1'b0;
  always #15 dram_ck = ~dram_ck;

  // Idle pins are a deselect with clock enable low.
  initial begin
    cke = 1'b0;
    pins = 4'hf;
  end

  // One clock-enable move with its command, then the level is held.
  // Mode-register set, read or other commands are sent only as noise while low or at refused moves.
  // The run stays at normal temperature, so no doubled refresh rate or
  // mode-register 2 setting is needed, and every low dwell is short.
  task automatic xfer(input logic k, input logic [3:0] c);
    int i;
    @(posedge dram_ck);
    cke <= k;
    pins <= c;
    for (i = 0; i < HOLD; i++) begin
      @(posedge dram_ck);
      // Noise while low would expose a device that still listens.
      pins <= k ? 4'hf : 4'($urandom);
    end
  endtask
endmodule // cps_ctrl_model

`default_nettype wire

// [bench/test_sdram_cke_power_state_control.sv]
`timescale 1ns/1ns
`default_nettype none

// --------------------------------------------
// Power-state bench with a status scoreboard.
// --------------------------------------------
module test_sdram_cke_power_state_control import cps_pkg::*;;
  localparam logic [3:0] NOP = {1'b0, CMD_NOP};
  localparam logic [3:0] REF = {1'b0, CMD_REF};
  localparam logic [3:0] DES = 4'hf;
  logic mclk, rst, dram_ck, cke, cs_n, ras_n, cas_n, we_n;
  logic odt, banks_open, op_busy, refresh_busy, timings_met;
  logic power_down, active_power_down, self_refresh, refresh_run;
  logic odt_enable, illegal_cmd, sr_wake;
  logic [4:0] exp_q[$];
  logic [4:0] obs;
  logic [2:0] st_prev;
  int num_errors, compares, c;

  always #2 mclk = ~mclk;

  cps_ctrl_model u_cps_ctrl_model (.dram_ck(dram_ck), .cke(cke),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n));

  cps_power_ctrl u_cps_power_ctrl (.mclk(mclk), .rst(rst),
    .dram_ck(dram_ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .odt(odt), .banks_open(banks_open),
    .op_busy(op_busy), .refresh_busy(refresh_busy),
    .timings_met(timings_met), .power_down(power_down),
    .active_power_down(active_power_down), .self_refresh(self_refresh),
    .refresh_run(refresh_run), .odt_enable(odt_enable),
    .illegal_cmd(illegal_cmd), .sr_wake(sr_wake));

  task automatic fail(input string msg);
    num_errors++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask

  task automatic check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) fail(msg);
  endtask

  task automatic final_report;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Waits for all noted results, then lingers to catch stray ones.
  task automatic settle;
    int i;
    for (i = 0; i < 3000 && exp_q.size() > 0; i++) @(posedge mclk);
    if (exp_q.size() > 0) begin
      fail("result never came");
      final_report;
    end
    repeat (40) @(posedge mclk);
  endtask

  // Core levels need two link edges to cross, so leave them time.
  task automatic core(input logic [3:0] v);
    @(posedge mclk);
    {banks_open, op_busy, refresh_busy, timings_met} <= v;
    repeat (30) @(posedge mclk);
  endtask

  // Code 5'h1f is impossible and means that no result is expected.
  task automatic step(input logic [4:0] e, input logic k,
                      input logic [3:0] cmd);
    if (e != 5'h1f) exp_q.push_back(e);
    u_cps_ctrl_model.xfer(k, cmd);
    settle;
  endtask

  // Every pulse or status change takes the oldest note off the queue.
  always @(negedge mclk) begin
    obs = {illegal_cmd, sr_wake, power_down, active_power_down,
           self_refresh};
    if (rst) st_prev = 3'h0;
    else if (obs[4:3] != 2'h0 || obs[2:0] != st_prev) begin
      st_prev = obs[2:0];
      compares++;
      if (exp_q.size() == 0) fail("status change not expected");
      else if (obs !== exp_q.pop_front()) fail("status mismatch");
    end
  end

  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    odt = 1'b1;
    {banks_open, op_busy, refresh_busy, timings_met} = 4'b0001;
    num_errors = 0;
    compares = 0;
    c = $urandom(32'h9b10);
    // Held long enough for four link edges as well.
    repeat (40) @(posedge mclk);
    rst <= 1'b0;
    repeat (5) @(posedge dram_ck);
    // The first rise after reset is no event; it only readies a fall.
    u_cps_ctrl_model.xfer(1'b1, DES);
    // Open banks: active power-down, left on a deselect.
    core(4'b1001);
    step(5'b00110, 1'b0, NOP);
    check(refresh_run === 1'b0, "refresh in power-down");
    step(5'b00000, 1'b1, DES);
    // Busy at the fall: entry waits until the operation ends.
    core(4'b1101);
    exp_q.push_back(5'b00110);
    u_cps_ctrl_model.xfer(1'b0, NOP);
    core(4'b1001);
    settle;
    step(5'b00000, 1'b1, NOP);
    // Refreshing with a plain fall goes to precharge power-down.
    core(4'b1011);
    step(5'b00100, 1'b0, NOP);
    step(5'b00000, 1'b1, DES);
    // Self refresh from idle, with termination asked for throughout.
    core(4'b0001);
    step(5'b00001, 1'b0, REF);
    check(refresh_run === 1'b1, "no refresh in self refresh");
    check(odt_enable === 1'b0, "termination in self refresh");
    exp_q.push_back(5'b01001);
    step(5'b00000, 1'b1, NOP);
    check(odt_enable === 1'b1, "termination after exit");
    odt <= 1'b0;
    repeat (10) @(posedge mclk);
    check(odt_enable === 1'b0, "termination not following its pin");
    odt <= 1'b1;
    // Every real command other than refresh at a fall is refused.
    for (c = 0; c < 7; c++) if (c != 1) begin
      step(5'b10000, 1'b0, {1'b0, c[2:0]});
      step(5'h1f, 1'b1, DES);
    end
    // Self-refresh entry refused for each missing idle condition.
    for (c = 0; c < 4; c++) begin
      core(4'b0001 ^ (4'b1000 >> c));
      step(5'b10000, 1'b0, REF);
      step(5'h1f, 1'b1, DES);
    end
    // A refused exit keeps self refresh; a clean exit follows.
    core(4'b0001);
    step(5'b00001, 1'b0, REF);
    exp_q.push_back(5'b01001);
    step(5'b10001, 1'b1, 4'h0);
    step(5'h1f, 1'b0, DES);
    exp_q.push_back(5'b01001);
    step(5'b00000, 1'b1, DES);
    // A refused exit keeps power-down; a second reset clears it.
    step(5'b00100, 1'b0, DES);
    c = $urandom_range(0, 6);
    step(5'b10100, 1'b1, {1'b0, c[2:0]});
    rst <= 1'b1;
    repeat (40) @(posedge mclk);
    rst <= 1'b0;
    repeat (5) @(posedge dram_ck);
    check(power_down === 1'b0, "state after reset");
    step(5'b00100, 1'b0, NOP);
    step(5'b00000, 1'b1, NOP);
    final_report;
  end
endmodule // test_sdram_cke_power_state_control

`default_nettype wire
